// file: hw/trxte_exec.sv
`timescale 1ns/10ps
module trxte_exec (
    input  wire logic                              clk_in,
    input  wire logic                              srst_in,
    input  wire logic                              instr_valid_in,
    input  wire logic [trxte_pkg::OP_W-1:0]        opcode_in,
    output logic                                   ready_out,
    input  wire logic [trxte_pkg::PTRL_W-1:0]      indirect_pointer_register_in,
    input  wire logic [trxte_pkg::PTRH_W-1:0]      table_pointer_high_in,
    output logic [trxte_pkg::PM_AW-1:0]            pm_addr_out,
    output logic                                   pm_rd_out,
    input  wire logic [trxte_pkg::OP_W-1:0]        pm_rdata_in,
    output logic [trxte_pkg::FADR_W-1:0]           reg_raddr_out,
    input  wire logic [trxte_pkg::DATA_W-1:0]      reg_rdata_in,
    output logic                                   reg_we_out,
    output logic [trxte_pkg::FADR_W-1:0]           reg_waddr_out,
    output logic [trxte_pkg::DATA_W-1:0]           reg_wdata_out,
    input  wire logic                              acc_load_in,
    input  wire logic [trxte_pkg::DATA_W-1:0]      acc_load_data_in,
    output logic [trxte_pkg::DATA_W-1:0]           acc_out,
    output logic                                   zero_flag_out
);
    import trxte_pkg::*;

    // ****************************************************************
    // decode
    // ****************************************************************
    trxte_state_t      state_q;
    trxte_state_t      state_d;
    logic [DATA_W-1:0] acc_q;
    logic              zero_q;
    logic [PM_AW-1:0]  pm_addr_q;
    logic              pm_rd_q;
    logic              reg_we_q;
    logic [FADR_W-1:0] reg_waddr_q;
    logic [DATA_W-1:0] reg_wdata_q;
    logic              take;
    logic              is_trl;
    logic              is_zt;
    logic              is_xl;
    logic              is_xr;
    logic              xr_to_reg;
    logic [DATA_W-1:0] xor_operand;
    logic [DATA_W-1:0] xor_result;
    logic [DATA_W-1:0] zsrc;
    logic              zsrc_zero;

    // nothing new is accepted while a table read holds the fetch path
    assign take      = instr_valid_in && (state_q == TRXTE_IDLE);
    assign is_trl    = take && (opcode_in == TRL_OP_VAL);
    assign is_zt     = take && ((opcode_in & ZT_MASK) == ZT_VAL);
    assign is_xl     = take && ((opcode_in & XOR_MASK) == XL_VAL);
    assign is_xr     = take && ((opcode_in & XOR_MASK) == XR_VAL);
    assign xr_to_reg = opcode_in[DEST_BIT];

    // register read address is combinational so one-cycle ops see data in time
    assign reg_raddr_out = opcode_in[FADR_W-1:0];

    assign xor_operand = is_xl ? opcode_in[DATA_W-1:0] : reg_rdata_in;
    assign xor_result  = acc_q ^ xor_operand;
    assign zsrc        = is_zt ? reg_rdata_in : xor_result;

    trxte_zero_detect u_zero (
        .value_in    (zsrc),
        .is_zero_out (zsrc_zero)
    );

    // ****************************************************************
    // table read sequencer
    // ****************************************************************
    always_comb begin
        state_d = state_q;
        case (state_q)
            TRXTE_IDLE: begin
                if (is_trl) begin
                    state_d = TRXTE_TR_WAIT;
                end
            end
            TRXTE_TR_WAIT: begin
                state_d = TRXTE_IDLE;
            end
            default: begin
                state_d = TRXTE_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_q <= TRXTE_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pm_addr_q <= '0;
            pm_rd_q   <= 1'b0;
        end else begin
            pm_rd_q <= is_trl;
            if (is_trl) begin
                pm_addr_q <= {table_pointer_high_in, indirect_pointer_register_in};
            end
        end
    end

    // ****************************************************************
    // accumulator
    // ****************************************************************
    // instruction results win over an external load in the same cycle
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            acc_q <= ACC_RST;
        end else if (state_q == TRXTE_TR_WAIT) begin
            acc_q <= pm_rdata_in[DATA_W-1:0];
        end else if (is_xl) begin
            acc_q <= xor_result;
        end else if (is_xr && !xr_to_reg) begin
            acc_q <= xor_result;
        end else if (acc_load_in) begin
            acc_q <= acc_load_data_in;
        end
    end

    // ****************************************************************
    // zero flag
    // ****************************************************************
    // table read leaves it alone, so only the three one-cycle ops write it
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            zero_q <= ZERO_RST;
        end else if (is_zt) begin
            zero_q <= zsrc_zero;
        end else if (is_xl || is_xr) begin
            zero_q <= zsrc_zero;
        end
    end

    // ****************************************************************
    // register write-back
    // ****************************************************************
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            reg_we_q    <= 1'b0;
            reg_waddr_q <= '0;
            reg_wdata_q <= '0;
        end else begin
            reg_we_q <= is_xr && xr_to_reg;
            if (is_xr && xr_to_reg) begin
                reg_waddr_q <= opcode_in[FADR_W-1:0];
                reg_wdata_q <= xor_result;
            end
        end
    end

    assign ready_out     = (state_q == TRXTE_IDLE);
    assign pm_addr_out   = pm_addr_q;
    assign pm_rd_out     = pm_rd_q;
    assign reg_we_out    = reg_we_q;
    assign reg_waddr_out = reg_waddr_q;
    assign reg_wdata_out = reg_wdata_q;
    assign acc_out       = acc_q;
    assign zero_flag_out = zero_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    property p_trl_decode;
        @(posedge clk_in) disable iff (srst_in)
        (instr_valid_in && ready_out && opcode_in == TRL_OP_VAL) |=> (pm_rd_out && !ready_out);
    endproperty
    a_trl_decode: assert property (p_trl_decode) else $error("table read not started");

    property p_trl_addr;
        @(posedge clk_in) disable iff (srst_in)
        is_trl |=> pm_addr_out == {$past(table_pointer_high_in), $past(indirect_pointer_register_in)};
    endproperty
    a_trl_addr: assert property (p_trl_addr) else $error("table address wrong");

    property p_trl_two_cycles;
        @(posedge clk_in) disable iff (srst_in)
        is_trl |=> !ready_out ##1 (ready_out && zero_flag_out == $past(zero_flag_out, 2));
    endproperty
    a_trl_two_cycles: assert property (p_trl_two_cycles) else $error("table read timing or flag");

    property p_trl_load;
        @(posedge clk_in) disable iff (srst_in)
        (state_q == TRXTE_TR_WAIT) |=> acc_out == $past(pm_rdata_in[DATA_W-1:0]);
    endproperty
    a_trl_load: assert property (p_trl_load) else $error("table byte not loaded");

    property p_zt_set;
        @(posedge clk_in) disable iff (srst_in)
        (is_zt && reg_rdata_in == 8'h00) |=> zero_flag_out;
    endproperty
    a_zt_set: assert property (p_zt_set) else $error("zero test did not set flag");

    property p_zt_only_flag;
        @(posedge clk_in) disable iff (srst_in)
        (is_zt && !acc_load_in) |=> (acc_out == $past(acc_out) && !reg_we_out && ready_out);
    endproperty
    a_zt_only_flag: assert property (p_zt_only_flag) else $error("zero test side effect");

    property p_zt_clear;
        @(posedge clk_in) disable iff (srst_in)
        (is_zt && reg_rdata_in != 8'h00) |=> !zero_flag_out;
    endproperty
    a_zt_clear: assert property (p_zt_clear) else $error("zero test did not clear flag");

    property p_xl_result;
        @(posedge clk_in) disable iff (srst_in)
        is_xl |=> acc_out == ($past(acc_out) ^ $past(opcode_in[DATA_W-1:0]));
    endproperty
    a_xl_result: assert property (p_xl_result) else $error("literal xor result wrong");

    property p_xl_flag;
        @(posedge clk_in) disable iff (srst_in)
        is_xl |=> (zero_flag_out == (acc_out == 8'h00) && !reg_we_out);
    endproperty
    a_xl_flag: assert property (p_xl_flag) else $error("literal xor flag wrong");

    property p_xr_dest;
        @(posedge clk_in) disable iff (srst_in)
        (is_xr && xr_to_reg && !acc_load_in) |=> (reg_we_out && acc_out == $past(acc_out)
            && reg_wdata_out == ($past(acc_out) ^ $past(reg_rdata_in))
            && reg_waddr_out == $past(opcode_in[FADR_W-1:0]));
    endproperty
    a_xr_dest: assert property (p_xr_dest) else $error("register xor write-back wrong");

    property p_xr_flag;
        @(posedge clk_in) disable iff (srst_in)
        is_xr |=> zero_flag_out == (($past(acc_out) ^ $past(reg_rdata_in)) == 8'h00);
    endproperty
    a_xr_flag: assert property (p_xr_flag) else $error("register xor flag wrong");
endmodule

// file: hw/trxte_pkg.sv
package trxte_pkg;
    // ****************************************************************
    // widths
    // ****************************************************************
    localparam int OP_W   = 14;
    localparam int DATA_W = 8;
    localparam int FADR_W = 7;
    localparam int PM_AW  = 14;
    localparam int PTRL_W = 8;
    localparam int PTRH_W = PM_AW - PTRL_W;

    // ****************************************************************
    // opcode patterns
    // ****************************************************************
    localparam logic [OP_W-1:0] TRL_OP_VAL = 14'h0050;
    localparam logic [OP_W-1:0] ZT_MASK    = 14'h3F80;
    localparam logic [OP_W-1:0] ZT_VAL     = 14'h0880;
    localparam logic [OP_W-1:0] XOR_MASK   = 14'h3F00;
    localparam logic [OP_W-1:0] XL_VAL     = 14'h1D00;
    localparam logic [OP_W-1:0] XR_VAL     = 14'h0600;
    localparam int              DEST_BIT   = 7;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
    localparam logic              ZERO_RST = 1'b0;

    typedef enum logic [0:0] {
        TRXTE_IDLE    = 1'b0,
        TRXTE_TR_WAIT = 1'b1
    } trxte_state_t;
endpackage

// file: hw/trxte_zero_detect.sv
`timescale 1ns/10ps
module trxte_zero_detect (
    input  wire logic [trxte_pkg::DATA_W-1:0] value_in,
    output logic                              is_zero_out
);
    import trxte_pkg::*;

    assign is_zero_out = (value_in == '0);
endmodule

// file: tb/table_read_xor_test_exec_test.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin \
    num_checks++; \
    if ((g) !== (e)) begin \
        $display("[ERR] %s exp %0h got %0h", nm, e, g); \
        mismatches++; \
    end \
end
module table_read_xor_test_exec_test;
    import trxte_pkg::*;
    typedef struct {
        int          cyc;
        logic [7:0]  acc;
        logic        zero, rdy, pmrd, we, rchk;
        logic [13:0] pmaddr;
        logic [6:0]  waddr, raddr;
        logic [7:0]  wdata;
    } trxte_note_t;

    logic        clk_in, srst_in, instr_valid_in, acc_load_in;
    logic [13:0] opcode_in, pm_rdata_in, pm_addr_out;
    logic [7:0]  indirect_pointer_register_in, reg_rdata_in, acc_load_data_in;
    logic [5:0]  table_pointer_high_in;
    logic        ready_out, pm_rd_out, reg_we_out, zero_flag_out;
    logic [6:0]  reg_raddr_out, reg_waddr_out;
    logic [7:0]  reg_wdata_out, acc_out;
    // ****************************************************************
    // reference state, kept by the driver as it issues each cycle
    // ****************************************************************
    logic [7:0]  acc_m, wd_m;
    logic [6:0]  wa_m;
    logic        z_m, busy_m;
    int          cyc, mismatches, num_checks, i, k;
    trxte_note_t q[$];
    trxte_note_t n_mon;
    trxte_note_t n_rst;

    trxte_exec trxte_exec_inst (
        .clk_in(clk_in), .srst_in(srst_in), .instr_valid_in(instr_valid_in),
        .opcode_in(opcode_in), .ready_out(ready_out),
        .indirect_pointer_register_in(indirect_pointer_register_in),
        .table_pointer_high_in(table_pointer_high_in), .pm_addr_out(pm_addr_out),
        .pm_rd_out(pm_rd_out), .pm_rdata_in(pm_rdata_in), .reg_raddr_out(reg_raddr_out),
        .reg_rdata_in(reg_rdata_in), .reg_we_out(reg_we_out), .reg_waddr_out(reg_waddr_out),
        .reg_wdata_out(reg_wdata_out), .acc_load_in(acc_load_in),
        .acc_load_data_in(acc_load_data_in), .acc_out(acc_out), .zero_flag_out(zero_flag_out)
    );

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // drives one cycle at the falling edge and notes what must show after the next rising edge
    task automatic step(input logic v, input logic [13:0] op, input logic ld,
                        input logic [7:0] ldat, input logic [7:0] rd);
        trxte_note_t n;
        logic [7:0]  res;
        @(negedge clk_in);
        instr_valid_in = v;
        opcode_in = op;
        acc_load_in = ld;
        acc_load_data_in = ldat;
        reg_rdata_in = rd;
        indirect_pointer_register_in = 8'($urandom);
        table_pointer_high_in = 6'($urandom);
        pm_rdata_in = 14'($urandom);
        n = '{default: '0};
        n.cyc = cyc + 1;
        n.rdy = 1'b1;
        n.raddr = op[6:0];
        res = acc_m ^ rd;
        if (v && !busy_m && op == 14'h0050) begin
            n.pmrd = 1'b1;
            n.pmaddr = {table_pointer_high_in, indirect_pointer_register_in};
            n.rdy = 1'b0;
            busy_m = 1'b1;
        end else if (v && !busy_m && op[13:7] == 7'h11) begin
            n.rchk = 1'b1;
            z_m = (rd == 8'h00);
        end else if (v && !busy_m && op[13:8] == 6'h1D) begin
            acc_m = acc_m ^ op[7:0];
            z_m = (acc_m == 8'h00);
        end else if (v && !busy_m && op[13:8] == 6'h06) begin
            n.rchk = 1'b1;
            z_m = (res == 8'h00);
            n.we = op[7];
            if (op[7]) begin
                wa_m = op[6:0];
                wd_m = res;
            end else begin
                acc_m = res;
            end
        end else if (busy_m) begin
            // upper program bits must never reach the accumulator
            acc_m = pm_rdata_in[7:0];
            busy_m = 1'b0;
        end else if (ld) begin
            acc_m = ldat;
        end
        n.acc = acc_m;
        n.zero = z_m;
        n.waddr = wa_m;
        n.wdata = wd_m;
        q.push_back(n);
    endtask

    // ****************************************************************
    // monitor: takes the oldest note when its cycle comes up
    // ****************************************************************
    always begin
        @(posedge clk_in);
        cyc++;
        #1;
        while (q.size() > 0 && q[0].cyc < cyc) begin
            $display("[ERR] note cycle exp %0d got %0d", q[0].cyc, cyc);
            mismatches++;
            void'(q.pop_front());
        end
        if (q.size() > 0 && q[0].cyc == cyc) begin
            n_mon = q.pop_front();
            `CHK("acc_out", n_mon.acc, acc_out)
            `CHK("zero_flag_out", n_mon.zero, zero_flag_out)
            `CHK("ready_out", n_mon.rdy, ready_out)
            `CHK("pm_rd_out", n_mon.pmrd, pm_rd_out)
            `CHK("reg_we_out", n_mon.we, reg_we_out)
            `CHK("reg_waddr_out", n_mon.waddr, reg_waddr_out)
            `CHK("reg_wdata_out", n_mon.wdata, reg_wdata_out)
            if (n_mon.pmrd) `CHK("pm_addr_out", n_mon.pmaddr, pm_addr_out)
            if (n_mon.rchk) `CHK("reg_raddr_out", n_mon.raddr, reg_raddr_out)
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        {instr_valid_in, acc_load_in, opcode_in, pm_rdata_in} = '0;
        {indirect_pointer_register_in, reg_rdata_in, acc_load_data_in} = '0;
        table_pointer_high_in = '0;
        {acc_m, wd_m, wa_m, z_m, busy_m} = '0;
        {cyc, mismatches, num_checks} = '0;
        srst_in = 1'b1;
        void'($urandom(71855));
        repeat (3) @(posedge clk_in);
        @(negedge clk_in);
        srst_in = 1'b0;
        step(1'b0, 14'h0000, 1'b0, 8'h00, 8'h00);
        step(1'b0, 14'h0000, 1'b1, 8'hB5, 8'h00);
        step(1'b1, 14'h1DAF, 1'b0, 8'h00, 8'h00);
        // literal equal to the accumulator gives zero, and beats a load in the same cycle
        step(1'b1, 14'h1D1A, 1'b1, 8'h55, 8'h00);
        step(1'b1, 14'h0050, 1'b0, 8'h00, 8'h00);
        step(1'b1, 14'h1D01, 1'b0, 8'h00, 8'h00);
        step(1'b1, 14'h1D01, 1'b0, 8'h00, 8'h00);
        for (i = 0; i < 400; i++) begin
            k = $urandom_range(0, 6);
            case (k)
                0: step(1'b0, 14'($urandom), 1'b0, 8'h00, 8'($urandom));
                1: step(1'b0, 14'h0000, !busy_m, 8'($urandom), 8'h00);
                2: step(1'b1, {7'h11, 7'($urandom)}, 1'b0, 8'h00,
                        ($urandom_range(0, 2) == 0) ? 8'h00 : 8'($urandom));
                3: step(1'b1, {6'h1D, ($urandom_range(0, 3) == 0) ? acc_m : 8'($urandom)},
                        !busy_m && 1'($urandom), 8'($urandom), 8'h00);
                4: step(1'b1, {6'h06, 8'($urandom)}, 1'b0, 8'h00,
                        ($urandom_range(0, 3) == 0) ? acc_m : 8'($urandom));
                5: step(1'b1, 14'h0050, 1'b0, 8'h00, 8'h00);
                default: step(1'b1, {2'b11, 12'($urandom)}, 1'b0, 8'h00, 8'($urandom));
            endcase
        end
        // mid-run reset with a live instruction and a load pending: reset must win
        @(negedge clk_in);
        srst_in = 1'b1;
        instr_valid_in = 1'b1;
        opcode_in = 14'h1D5A;
        acc_load_in = 1'b1;
        acc_load_data_in = 8'hC3;
        {acc_m, wd_m, wa_m, z_m, busy_m} = '0;
        n_rst = '{default: '0};
        n_rst.cyc = cyc + 1;
        n_rst.rdy = 1'b1;
        q.push_back(n_rst);
        @(negedge clk_in);
        srst_in = 1'b0;
        instr_valid_in = 1'b0;
        acc_load_in = 1'b0;
        step(1'b1, 14'h1D3C, 1'b0, 8'h00, 8'h00);
        step(1'b1, 14'h0050, 1'b0, 8'h00, 8'h00);
        step(1'b1, 14'h0885, 1'b0, 8'h00, 8'h00);
        step(1'b1, 14'h0885, 1'b0, 8'h00, 8'h00);
        step(1'b0, 14'h0000, 1'b0, 8'h00, 8'h00);
        for (i = 0; i < 10 && q.size() > 0; i++) begin
            @(posedge clk_in);
        end
        if (q.size() > 0) begin
            $display("[ERR] note queue exp 0 got %0d", q.size());
            mismatches++;
        end
        complete_run();
    end
endmodule
